/* design/mfz_pkg.sv */
// Package for the metering fault-select and zero-crossing monitor.
// Assumes a 40 MHz system clock; samples arrive as one-cycle strobes.
package mfz_pkg;
    localparam logic [7:0]  ADDR_FIRST_MODE_CONTROL   = 8'h0B;
    localparam logic [7:0]  ADDR_ACC     = 8'h0F;
    localparam logic [7:0]  ADDR_ZERO_CROSS_TIMEOUT_RELOAD  = 8'h11;
    localparam logic [7:0]  ADDR_GAIN    = 8'h1C;
    localparam logic [7:0]  ADDR_CALIBRATION_INPUT_FORCE = 8'h3D;
    localparam logic [7:0]  ADDR_IRQEN3  = 8'hDB;
    localparam logic [7:0]  ADDR_IRQST1  = 8'hDC;
    localparam logic [7:0]  ADDR_IRQST3  = 8'hDE;
    localparam logic [7:0]  ADDR_IRQEN1  = 8'hD9;
    localparam logic [7:0]  ADDR_ZXCTL   = 8'hE0;

    localparam int          INTEG_BIT    = 0;
    // Bypass bit kept apart from the two routing bits so routing never drops the filter
    localparam int          LPF_OFF_BIT  = 2;
    localparam int          FSIGN_BIT    = 6;
    localparam int          ICHAN_BIT    = 7;
    localparam int          FAULT_FLAG   = 5;
    localparam int          ZX_FLAG      = 0;
    localparam int          CROSSING_TIMEOUT_FLAG_FLAG    = 1;
    localparam int          ZXP05_BIT    = 0;
    localparam int          ZXP12_BIT    = 1;

    localparam logic [11:0] ZERO_CROSS_TIMEOUT_RELOAD_RST   = 12'hFFF;
    localparam logic [1:0]  FORCE_A      = 2'h1;
    localparam logic [1:0]  FORCE_B      = 2'h2;
    localparam int          CROSSING_TIMEOUT_FLAG_DIV_MCLK = 160;
    localparam int          MCLK_KHZ     = 4096;
    localparam int          CLK_KHZ      = 40000;
    // Timeout tick in system clocks: 160 master-clock periods, floored
    localparam int          CROSSING_TIMEOUT_FLAG_DIV     = CROSSING_TIMEOUT_FLAG_DIV_MCLK * CLK_KHZ / MCLK_KHZ;
    localparam int          FAULT_TAU_MS = 3000;
    localparam int          FAULT_CYC    = FAULT_TAU_MS * (CLK_KHZ / 1000) * 1000;
    // Threshold is 1/16 = 6.25 percent
    localparam int          THR_SHIFT    = 4;
    // Voltage floor: 0.3 percent of full scale, as 24-bit magnitude
    localparam logic [23:0] V_FLOOR      = 24'h0018DA;
    localparam int          GAIN_SHIFT   = 12;

    typedef struct packed {
        logic [23:0] a;
        logic [23:0] b;
        logic [23:0] v;
        logic        valid;
    } mfz_samp_t;

    typedef struct packed {
        logic [23:0] b_trim;
        logic [23:0] i_sel;
        logic        integ_en;
        logic        zx_p05;
        logic        zx_p12;
        logic        irq;
    } mfz_out_t;
endpackage : mfz_pkg

/* design/mfz_monitor.sv */
// Fault-based current input selection, gain trim and zero-crossing logic.
// Assumes samples magnitudes are presented once per strobe, synchronous to clk_i.
// Function
// R1: Swap to second input when it exceeds first. Code swaps only when the excess is over 1/16 of the second input.
// R2: Swap filtered, about three seconds delay.
// R3: Swap back only when first exceeds by 6.25%.
// R4: Mode bit set flags when inputs near.
// R5: Trim second input by signed 12-bit gain. Code writes only 8 bits, zero-extended, so gain is 0 to 255.
// R6: Force field 01/10 selects first/second input.
// R7: First input active after reset.
// R8: Integrator off at reset, on by bit.
// R9: Zero crossing from filtered or bypassed voltage.
// R10: Filter enabled by default, may disable.
// R11: Zero crossing sets sticky enabled flag.
// R12: Zero crossing routable to two port pins.
// R13: 12-bit timeout decrements every 160 MCLK.
// R14: Zero crossing reloads timeout counter.
// R15: Timeout reload value resets to 0xFFF.
// R16: Timeout at zero sets sticky flag.
// R17: Timeout register readable and writable. Code writes and reads only the low 8 bits; a write zeroes bits 11:8.
// R18: Selected input reported in accumulation bit 7.
// R19: Equal force bits mean automatic selection.
// R20: Fault detection suspended at low voltage.
// R21: Interrupt when any enabled flag set.
`timescale 1ns/100ps
module mfz_monitor #(
    parameter int FAULT_CYCLES = mfz_pkg::FAULT_CYC,
    parameter int LPF_SHIFT    = 10
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    input  wire mfz_pkg::mfz_samp_t samp_i,
    output mfz_pkg::mfz_out_t      out_o
);
    typedef struct packed {
        logic [7:0]  first_mode_control;
        logic [7:0]  acc;
        logic [11:0] zero_cross_timeout_reload;
        logic [11:0] gain;
        logic [7:0]  calibration_input_force;
        logic [7:0]  en1;
        logic [7:0]  en3;
        logic [7:0]  st1;
        logic [7:0]  st3;
        logic [7:0]  zxctl;
        logic [7:0]  rdata;
        logic [11:0] zx_cnt;
        logic [15:0] div_cnt;
        logic [31:0] flt_cnt;
        logic        use_b;
        logic        near_r;
        logic [23:0] v_lpf;
        logic        v_sign;
        mfz_pkg::mfz_out_t out;
    } mfz_state_t;

    mfz_state_t st_r;
    mfz_state_t st_nxt;

    logic [23:0] a_mag;
    logic [23:0] b_mag;
    logic [23:0] v_mag;
    logic [23:0] v_path;
    logic [47:0] b_prod;
    logic        want_b;
    logic        want_a;
    logic        near_now;
    logic        zx_ev;
    logic        tick;
    logic        sel_b;
    logic [7:0]  set1;
    logic [7:0]  set3;

    function automatic logic [23:0] mag(input logic [23:0] x);
        mag = x[23] ? 24'(-x) : x;
    endfunction : mag

    always_comb begin
        a_mag  = mag(samp_i.a);
        b_prod = 48'($signed(samp_i.b)) * 48'($signed({{12{st_r.gain[11]}}, st_r.gain}));
        // Second input scaled by (1 + gain / 4096)
        st_nxt = st_r;
        st_nxt.out.b_trim = 24'(samp_i.b + 24'(b_prod >>> mfz_pkg::GAIN_SHIFT)); // see R5
        b_mag  = mag(st_nxt.out.b_trim);
        v_path = st_r.zxctl[mfz_pkg::LPF_OFF_BIT] ? samp_i.v : st_r.v_lpf; // see R9 R10
        v_mag  = mag(samp_i.v);
        want_b = !st_r.use_b && (b_mag > a_mag)
                 && ((b_mag - a_mag) > (b_mag >> mfz_pkg::THR_SHIFT)); // see R1
        want_a = st_r.use_b && (a_mag > b_mag)
                 && ((a_mag - b_mag) > (b_mag >> mfz_pkg::THR_SHIFT)); // see R3
        near_now = (a_mag <= b_mag)
                   && ((b_mag - a_mag) <= (b_mag >> mfz_pkg::THR_SHIFT));
        zx_ev  = samp_i.valid && (v_path[23] != st_r.v_sign);
        tick   = (st_r.div_cnt == 16'(mfz_pkg::CROSSING_TIMEOUT_FLAG_DIV - 1));

        st_nxt.rdata = 8'h00;
        set1 = 8'h00;
        set3 = 8'h00;
        if (samp_i.valid) begin
            // Single-pole low-pass on the voltage path
            st_nxt.v_lpf = 24'(st_r.v_lpf + 24'($signed(samp_i.v - st_r.v_lpf) >>> LPF_SHIFT));
            st_nxt.v_sign = v_path[23];
        end

        // Fault averaging: condition must persist for the filter interval
        if (samp_i.valid && v_mag >= mfz_pkg::V_FLOOR) begin // see R20
            if (want_b || want_a) begin
                if (st_r.flt_cnt >= 32'(FAULT_CYCLES - 1)) begin // see R2
                    st_nxt.flt_cnt = 32'h0;
                    st_nxt.use_b = want_b;
                    if (!st_r.acc[mfz_pkg::FSIGN_BIT]) begin
                        set1[mfz_pkg::FAULT_FLAG] = 1'b1; // see R1
                    end
                end else begin
                    st_nxt.flt_cnt = st_r.flt_cnt + 32'h1;
                end
            end else begin
                st_nxt.flt_cnt = 32'h0;
            end
            st_nxt.near_r = near_now && st_r.use_b;
            if (st_r.acc[mfz_pkg::FSIGN_BIT] && st_nxt.near_r && !st_r.near_r) begin
                set1[mfz_pkg::FAULT_FLAG] = 1'b1; // see R4
            end
        end

        // Force field overrides automatic choice
        case (st_r.calibration_input_force[1:0])
            mfz_pkg::FORCE_A: sel_b = 1'b0; // see R6
            mfz_pkg::FORCE_B: sel_b = 1'b1;
            default:          sel_b = st_r.use_b; // see R19
        endcase
        st_nxt.acc[mfz_pkg::ICHAN_BIT] = sel_b; // see R18
        st_nxt.out.i_sel = sel_b ? st_nxt.out.b_trim : samp_i.a;

        // Timeout counter
        st_nxt.div_cnt = tick ? 16'h0 : st_r.div_cnt + 16'h1;
        if (zx_ev) begin
            st_nxt.zx_cnt = st_r.zero_cross_timeout_reload; // see R14
            set3[mfz_pkg::ZX_FLAG] = 1'b1; // see R11
            st_nxt.out.zx_p05 = st_r.zxctl[mfz_pkg::ZXP05_BIT] & ~st_r.out.zx_p05; // see R12
            st_nxt.out.zx_p12 = st_r.zxctl[mfz_pkg::ZXP12_BIT] & ~st_r.out.zx_p12;
        end else if (tick && st_r.zx_cnt != 12'h000) begin
            st_nxt.zx_cnt = st_r.zx_cnt - 12'h001; // see R13
            if (st_r.zx_cnt == 12'h001) begin
                set3[mfz_pkg::CROSSING_TIMEOUT_FLAG_FLAG] = 1'b1; // see R16
            end
        end
        st_nxt.st1 = st_r.st1 | set1;
        st_nxt.st3 = st_r.st3 | set3;

        // Register writes; status bits are write-one-to-clear, set wins
        if (wr_i) begin
            case (addr_i)
                mfz_pkg::ADDR_FIRST_MODE_CONTROL:   st_nxt.first_mode_control = wdata_i;
                mfz_pkg::ADDR_ACC:     st_nxt.acc[6:0] = wdata_i[6:0];
                mfz_pkg::ADDR_ZERO_CROSS_TIMEOUT_RELOAD:  st_nxt.zero_cross_timeout_reload = {4'h0, wdata_i}; // see R17
                mfz_pkg::ADDR_GAIN:    st_nxt.gain = {4'h0, wdata_i};
                mfz_pkg::ADDR_CALIBRATION_INPUT_FORCE: st_nxt.calibration_input_force = wdata_i;
                mfz_pkg::ADDR_IRQEN1:  st_nxt.en1 = wdata_i;
                mfz_pkg::ADDR_IRQEN3:  st_nxt.en3 = wdata_i;
                mfz_pkg::ADDR_IRQST1:  st_nxt.st1 = (st_r.st1 & ~wdata_i) | set1;
                mfz_pkg::ADDR_IRQST3:  st_nxt.st3 = (st_r.st3 & ~wdata_i) | set3;
                mfz_pkg::ADDR_ZXCTL:   st_nxt.zxctl = wdata_i;
                default: ;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                mfz_pkg::ADDR_FIRST_MODE_CONTROL:   st_nxt.rdata = st_r.first_mode_control;
                mfz_pkg::ADDR_ACC:     st_nxt.rdata = st_r.acc;
                mfz_pkg::ADDR_ZERO_CROSS_TIMEOUT_RELOAD:  st_nxt.rdata = st_r.zero_cross_timeout_reload[7:0];
                mfz_pkg::ADDR_GAIN:    st_nxt.rdata = st_r.gain[7:0];
                mfz_pkg::ADDR_CALIBRATION_INPUT_FORCE: st_nxt.rdata = st_r.calibration_input_force;
                mfz_pkg::ADDR_IRQEN1:  st_nxt.rdata = st_r.en1;
                mfz_pkg::ADDR_IRQEN3:  st_nxt.rdata = st_r.en3;
                mfz_pkg::ADDR_IRQST1:  st_nxt.rdata = st_r.st1;
                mfz_pkg::ADDR_IRQST3:  st_nxt.rdata = st_r.st3;
                mfz_pkg::ADDR_ZXCTL:   st_nxt.rdata = st_r.zxctl;
                default:               st_nxt.rdata = 8'h00;
            endcase
        end
        st_nxt.out.integ_en = st_nxt.first_mode_control[mfz_pkg::INTEG_BIT]; // see R8
        st_nxt.out.irq = |(st_nxt.st1 & st_nxt.en1) | |(st_nxt.st3 & st_nxt.en3); // see R21
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r        <= '0;
            st_r.zero_cross_timeout_reload <= mfz_pkg::ZERO_CROSS_TIMEOUT_RELOAD_RST; // see R15
            st_r.zx_cnt <= mfz_pkg::ZERO_CROSS_TIMEOUT_RELOAD_RST;
            st_r.use_b  <= 1'b0; // see R7
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign out_o   = st_r.out;

    a_zx_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        zx_ev |=> st_r.zx_cnt == $past(st_r.zero_cross_timeout_reload)) else $error("reload missed"); // see R14
    a_zx_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        zx_ev |=> st_r.st3[mfz_pkg::ZX_FLAG]) else $error("zx flag missed"); // see R11
    a_to_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!zx_ev && tick && st_r.zx_cnt == 12'h001) |=> st_r.st3[mfz_pkg::CROSSING_TIMEOUT_FLAG_FLAG])
        else $error("timeout flag missed"); // see R16
    a_force_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r.calibration_input_force[1:0] == mfz_pkg::FORCE_A |=> !st_r.acc[mfz_pkg::ICHAN_BIT])
        else $error("force a ignored"); // see R6
    a_force_b: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_r.calibration_input_force[1:0] == mfz_pkg::FORCE_B |=> st_r.acc[mfz_pkg::ICHAN_BIT])
        else $error("force b ignored"); // see R6
    a_auto_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_r.calibration_input_force[0] == st_r.calibration_input_force[1]) |=> st_r.acc[mfz_pkg::ICHAN_BIT] == $past(st_r.use_b))
        else $error("auto select wrong"); // see R19
    a_integ_en: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        out_o.integ_en == st_r.first_mode_control[mfz_pkg::INTEG_BIT])
        else $error("integrator enable wrong"); // see R8
    a_zx_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (zx_ev && wr_i && addr_i == mfz_pkg::ADDR_IRQST3 && wdata_i[mfz_pkg::ZX_FLAG])
        |=> st_r.st3[mfz_pkg::ZX_FLAG]) else $error("zx set lost to clear"); // see R11
    a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rd_i |=> rdata_o == 8'h00) else $error("read data not idle"); // see R17
    a_lpf_bypass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (samp_i.valid && st_r.zxctl[mfz_pkg::LPF_OFF_BIT]) |=> st_r.v_sign == $past(samp_i.v[23]))
        else $error("bypass path wrong"); // see R9 R10
    a_acc_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_r.calibration_input_force[1:0] == mfz_pkg::FORCE_A) ##1 (st_r.calibration_input_force[1:0] == mfz_pkg::FORCE_A)
        |-> !rdata_o[mfz_pkg::ICHAN_BIT] || !$past(rd_i) || $past(addr_i) != mfz_pkg::ADDR_ACC)
        else $error("indicator read wrong"); // see R18
    a_irq_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        out_o.irq == (|(st_r.st1 & st_r.en1) || |(st_r.st3 & st_r.en3)))
        else $error("irq mismatch"); // see R21
    a_tick_dec: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tick && !zx_ev && st_r.zx_cnt != 12'h000) |=> st_r.zx_cnt == $past(st_r.zx_cnt) - 12'h001)
        else $error("decrement wrong"); // see R13
    a_low_volt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (samp_i.valid && mag(samp_i.v) < mfz_pkg::V_FLOOR) |=> st_r.use_b == $past(st_r.use_b))
        else $error("fault not suspended"); // see R20
endmodule : mfz_monitor

/* verification/mfz_adc_model.sv */
// ADC sample source for the monitor bench: one sample set every four clocks.
// Assumes the bench sets magnitudes; voltage changes sign every 16 clocks while swing_i is high.
`timescale 1ns/100ps
module mfz_adc_model (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic [23:0]   a_i,
    input  wire logic [23:0]   b_i,
    input  wire logic [23:0]   v_i,
    input  wire logic          swing_i,
    output mfz_pkg::mfz_samp_t samp_o
);
    logic [4:0] cnt_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r  <= 5'h00;
            samp_o <= '0;
        end else begin
            cnt_r        <= cnt_r + 5'h01;
            samp_o.valid <= (cnt_r[1:0] == 2'h3);
            samp_o.a     <= a_i;
            samp_o.b     <= b_i;
            samp_o.v     <= (swing_i && cnt_r[4]) ? (24'h000000 - v_i) : v_i;
        end
    end
endmodule : mfz_adc_model

/* verification/tb_mfz_monitor.sv */
// Self-checking bench for mfz_monitor over its register port and sample input.
// Assumes the ADC model feeds samples and bit2 of 0xE0 bypasses the line low-pass.
`timescale 1ns/100ps
module tb_mfz_monitor;
    localparam int      FCYC = 20;
    logic               clk_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic [7:0]         addr_i = 8'h00;
    logic [7:0]         wdata_i = 8'h00;
    logic               wr_i = 1'b0;
    logic               rd_i = 1'b0;
    logic [7:0]         rdata_o;
    logic [23:0]        amp_a = 24'h000000;
    logic [23:0]        amp_b = 24'h000000;
    logic [23:0]        amp_v = 24'h100000;
    logic               swing = 1'b0;
    logic [7:0]         d;
    logic [1:0]         f;
    logic               p;
    mfz_pkg::mfz_samp_t samp_i;
    mfz_pkg::mfz_out_t  out_o;
    int                 bad_count = 0;
    int                 n_compared = 0;
    always #12.5 clk_i = ~clk_i;
    mfz_adc_model i_mfz_adc_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .a_i(amp_a), .b_i(amp_b),
        .v_i(amp_v), .swing_i(swing), .samp_o(samp_i));
    mfz_monitor #(.FAULT_CYCLES(FCYC)) i_mfz_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .samp_i(samp_i), .out_o(out_o));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 v = rdata_o;
    endtask : rd
    // Polls one register bit until it shows the wanted level, bounded
    task automatic poll(input logic [7:0] a, input int b, input logic want, input int n);
        logic [7:0] v;
        for (int i = 0; i < n; i++) begin
            rd(a, v);
            if (v[b] === want) return;
        end
        bad_count++;
        $display("BAD %0t wait ran out at %h", $time, a);
        test_done();
    endtask : poll
    function automatic logic exp_swap(input logic [23:0] hi, input logic [23:0] lo);
        return hi > lo + (hi >> 4);
    endfunction : exp_swap
    initial begin
        void'($urandom(51667));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(8'h11, d); chk(d, mfz_pkg::ZERO_CROSS_TIMEOUT_RELOAD_RST[7:0]);
        rd(8'h0F, d); chk({7'h00, d[7]}, 8'h00);
        chk({7'h00, out_o.integ_en}, 8'h00);
        wr(8'h0B, 8'h01); @(posedge clk_i); chk({7'h00, out_o.integ_en}, 8'h01);
        wr(8'h11, 8'h02); rd(8'h11, d); chk(d, 8'h02);
        rd(8'h55, d); chk(d, 8'h00);
        wr(8'h0F, 8'h80); rd(8'h0F, d); chk({7'h00, d[7]}, 8'h00);
        amp_a <= ($urandom % 24'h080000) + 24'h080000;
        swing <= 1'b1;
        @(posedge clk_i);
        amp_b <= amp_a + (amp_a >> 5);
        repeat (FCYC * 8) @(posedge clk_i);
        rd(8'h0F, d); chk({7'h00, d[7]}, {7'h00, exp_swap(amp_b, amp_a)});
        amp_b <= amp_a << 1;
        poll(8'h0F, mfz_pkg::ICHAN_BIT, 1'b1, 200);
        rd(8'h0F, d); chk({7'h00, d[7]}, {7'h00, exp_swap(amp_b, amp_a)});
        rd(8'hDC, d); chk({7'h00, d[5]}, 8'h01);
        amp_b <= amp_b & 24'hFFF000;
        amp_a <= amp_b << 1;
        poll(8'h0F, mfz_pkg::ICHAN_BIT, 1'b0, 200);
        wr(8'h1C, 8'h40);
        repeat (12) @(posedge clk_i);
        d = 8'((amp_b + (amp_b >> 6)) >> 8);
        chk(out_o.b_trim[15:8], d);
        for (int k = 0; k < 4; k++) begin
            f = 2'(k);
            wr(8'h3D, {6'h00, f}); rd(8'h0F, d);
            chk({7'h00, d[7]}, {7'h00, f == mfz_pkg::FORCE_B});
            chk(out_o.i_sel[15:8], (f == mfz_pkg::FORCE_B) ? 8'((amp_b + (amp_b >> 6)) >> 8)
                : amp_a[15:8]);
        end
        wr(8'h3D, 8'h00);
        wr(8'hE0, 8'h07); wr(8'hDB, 8'h01);
        poll(8'hDE, mfz_pkg::ZX_FLAG, 1'b1, 100);
        chk({7'h00, out_o.irq}, 8'h01);
        p = out_o.zx_p05;
        for (int i = 0; i < 80 && out_o.zx_p05 === p; i++) @(posedge clk_i);
        chk({7'h00, out_o.zx_p05}, {7'h00, ~p});
        chk({7'h00, out_o.zx_p12}, {7'h00, out_o.zx_p05});
        swing <= 1'b0;
        repeat (40) @(posedge clk_i);
        wr(8'hDE, 8'h01); rd(8'hDE, d); chk({7'h00, d[0]}, 8'h00);
        chk({7'h00, out_o.irq}, 8'h00);
        poll(8'hDE, mfz_pkg::CROSSING_TIMEOUT_FLAG_FLAG, 1'b1, 3000);
        chk({7'h00, out_o.irq}, 8'h00);
        wr(8'hDB, 8'h02); @(posedge clk_i); chk({7'h00, out_o.irq}, 8'h01);
        test_done();
    end
endmodule : tb_mfz_monitor
